// ---- hdl/i2c_host_pkg.sv ----
// Purpose: Shared constants and types of the two-wire host flag block
// Assumes: 20 MHz register clock, 32-bit AXI4-Lite register bus
// Notes: Register byte address is four times the register index
package i2c_host_pkg;
  localparam int ADDR_W = 10;
  localparam int CLK_NS = 50;
  localparam int HALF_NS = 5000;
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int TOUT_US = 25000;
  localparam int TOUT_CYC = TOUT_US * 1000 / CLK_NS;
  localparam int SYNC_CYC = 2;
  localparam logic [7:0] IDX_CTRL = 8'h04;
  localparam logic [7:0] IDX_FLAGS = 8'h0e;
  localparam logic [7:0] IDX_STATUS = 8'h10;
  localparam logic [7:0] IDX_ADDR = 8'h14;
  localparam logic [7:0] IDX_DATA = 8'h18;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int F_MB = 0;
  localparam int F_SB = 1;
  localparam int S_ERR = 0;
  localparam int S_ARB = 1;
  localparam int S_NACK = 2;
  localparam int S_BS = 4;
  localparam int S_TOUT = 6;
  localparam int S_HOLD = 7;
  localparam int S_SYNC = 10;
  localparam int C_SYSTEM_OP_PENDING = 0;
  localparam int C_AUTO = 8;
  localparam int C_CMD = 16;
  localparam int C_ACK = 18;
  localparam logic [1:0] CMD_RSTART = 2'h1;
  localparam logic [1:0] CMD_READ = 2'h2;
  localparam logic [1:0] CMD_STOP = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    BS_UNKNOWN = 2'h0, BS_IDLE = 2'h1, BS_OWNER = 2'h2, BS_BUSY = 2'h3
  } bus_state_type;
  typedef enum logic [3:0] {
    E_IDLE = 4'h0, E_WAIT = 4'h1, E_START = 4'h2, E_LOW = 4'h3,
    E_HIGH = 4'h4, E_HOLD = 4'h5, E_RST = 4'h6, E_RST2 = 4'h7,
    E_STOP = 4'h8, E_STOP2 = 4'h9
  } eng_type;
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_type;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_type;
  typedef struct packed {
    logic scl_out;
    logic scl_oe_n;
    logic sda_out;
    logic sda_oe_n;
  } pins_type;
endpackage

// ---- hdl/i2c_host_flags.sv ----
// Purpose: Two-wire bus host with flags, status, address and data
// Assumes: Open-drain pins, output enable low while driving low
// Notes: Bit timing is a fixed half period; no baud register here
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
// Behaviour
// - Received read byte sets client flag, stretches
// - Address, data, smart read, command release
// - Client flag write-one clears, waits for release
// - Host flag set after each transmitted byte except an acknowledged read address
// - Host flag on lost NACK or unknown start
// - Host flag stretches unless lost or unknown start; write-one clears
// - Sync busy bit tracks register synchronisation
// - Clock hold shows stretch; writing it releases
// - Low time-out flag, cleared by one or address
// - Bus state: unknown, idle, owner, busy
// - Software forces unknown to idle only
// - Received NACK bit read only
// - Arbitration lost on bit, NACK, start
// - Arbitration lost cleared by address or one
// - Bus error on illegal start, stop, time-out
// - Owner bus error also loses arbitration
// - Address write: unknown errors, busy waits
// - Idle address write: start, address, hold
// - Owner address write: repeated start, clear flags
// - Address bit zero is direction; reads harmless
// - Data write while held triggers next operation; read only with auto ACK on a received byte
// - Commands: repeated start, read, stop
// - Acknowledge select: zero ACK, one NACK
module i2c_host_flags #(
  parameter int HALF_CYC = i2c_host_pkg::HALF_CYC,
  parameter int TOUT_CYC = i2c_host_pkg::TOUT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire i2c_host_pkg::axi_req_type req,
  output i2c_host_pkg::axi_rsp_type rsp,
  input wire logic scl_in,
  input wire logic sda_in,
  output i2c_host_pkg::pins_type pins
);
  import i2c_host_pkg::*;

  typedef struct packed {
    axi_rsp_type rsp;
    pins_type pins;
    logic aw_ok;
    logic [ADDR_W-1:0] aw;
    logic w_ok;
    logic [31:0] wd;
    logic [3:0] ws;
    logic mb, sb, illegal_condition_flag, arb, last_byte_refused, tout, hold, sync, system_op_pending;
    logic autoack, ack_response_select, rd, addrph, rxh, fresh, scl, sda;
    bus_state_type bs;
    eng_type eng;
    logic [1:0] nxt;
    logic [7:0] addr, dat, sh;
    logic [3:0] bitn;
    logic [15:0] hc;
    logic [19:0] tc;
    logic [1:0] sc;
    logic [2:0] scl_s, sda_s;
  } state_type;

  state_type s, next_s;
  logic f_scl, f_sda, start_ev, stop_ev, wr_fire, rel, ack_first, sync_go;
  logic set_mb, set_sb, set_arb, set_err, set_tout, lost, tx, sending;
  logic [7:0] widx, ridx;
  logic [31:0] wm, rdv;
  logic [1:0] op, cmd;
  eng_type dst;

  function automatic logic mapped(input logic [7:0] i);
    mapped = i == IDX_CTRL || i == IDX_FLAGS || i == IDX_STATUS ||
             i == IDX_ADDR || i == IDX_DATA;
  endfunction

  // Change counts once second and third stages agree
  assign f_scl = (s.scl_s[1] == s.scl_s[2]) ? s.scl_s[2] : s.scl;
  assign f_sda = (s.sda_s[1] == s.sda_s[2]) ? s.sda_s[2] : s.sda;
  assign start_ev = s.scl & f_scl & s.sda & !f_sda;
  assign stop_ev = s.scl & f_scl & !s.sda & f_sda;
  assign wr_fire = s.aw_ok & s.w_ok & !s.rsp.bvalid;
  assign widx = s.aw[9:2];
  assign ridx = req.araddr[9:2];
  assign tx = s.addrph | !s.rd;
  assign rsp = s.rsp;
  assign pins = s.pins;

  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign wm[8*i +: 8] = s.ws[i] ? s.wd[8*i +: 8] : 8'h00;
  end

  always_comb begin
    next_s = s;
    {set_mb, set_sb, set_arb, set_err, set_tout} = 5'h00;
    {rel, ack_first, sync_go, lost, sending} = 5'h00;
    op = CMD_READ;
    cmd = 2'h0;
    dst = E_IDLE;
    rdv = 32'h0;
    next_s.hc = s.hc + 16'h1;
    next_s.scl_s = {s.scl_s[1:0], scl_in};
    next_s.sda_s = {s.sda_s[1:0], sda_in};
    next_s.scl = f_scl;
    next_s.sda = f_sda;

    case (s.eng)
      E_IDLE: next_s.pins.sda_oe_n = 1'b1;
      E_WAIT: begin
        if (s.bs == BS_IDLE) begin
          next_s.eng = E_START;
          next_s.hc = 16'h0;
          next_s.bs = BS_OWNER;
        end
      end
      E_START: begin
        if (s.hc < 16'(HALF_CYC) && !s.sda) begin
          lost = 1'b1;
        end else begin
          next_s.pins.sda_oe_n = !(s.hc >= 16'(HALF_CYC - 1));
          if (s.hc == 16'(2 * HALF_CYC - 1)) begin
            next_s.eng = E_LOW;
            next_s.hc = 16'h0;
            next_s.bitn = 4'h0;
            next_s.sh = s.addr;
          end
        end
      end
      E_LOW: begin
        if (s.bitn < 4'h8)
          next_s.pins.sda_oe_n = tx ? s.sh[7] : 1'b1;
        else
          next_s.pins.sda_oe_n = tx ? 1'b1 : s.ack_response_select;
        if (s.hc == 16'(HALF_CYC - 1)) begin
          next_s.eng = E_HIGH;
          next_s.hc = 16'h0;
        end
      end
      E_HIGH: begin
        // Stretching by a client simply delays the high half
        if (!f_scl) begin
          next_s.hc = 16'h0;
        end else if (s.hc == 16'(HALF_CYC - 1)) begin
          next_s.hc = 16'h0;
          sending = s.pins.sda_oe_n & ((s.bitn < 4'h8) ? tx : !tx);
          next_s.sh = tx ? {s.sh[6:0], 1'b0} : {s.sh[6:0], s.sda};
          if (sending && !s.sda) begin
            lost = 1'b1;
          end else if (s.bitn < 4'h7 || (s.bitn == 4'h7 && tx)) begin
            next_s.bitn = s.bitn + 4'h1;
            next_s.eng = E_LOW;
          end else if (s.bitn == 4'h7) begin
            next_s.dat = {s.sh[6:0], s.sda};
            set_sb = 1'b1;
            next_s.hold = 1'b1;
            next_s.rxh = 1'b1;
            next_s.eng = E_HOLD;
          end else if (tx) begin
            next_s.last_byte_refused = s.sda;
            next_s.addrph = 1'b0;
            if (s.addrph && s.rd && !s.sda) begin
              next_s.bitn = 4'h0;
              next_s.eng = E_LOW;
            end else begin
              set_mb = 1'b1;
              next_s.hold = 1'b1;
              next_s.rxh = 1'b0;
              next_s.eng = E_HOLD;
            end
          end else begin
            next_s.bitn = 4'h0;
            case (s.nxt)
              CMD_READ: next_s.eng = E_LOW;
              CMD_RSTART: next_s.eng = E_RST;
              default: next_s.eng = E_STOP;
            endcase
          end
        end
      end
      E_HOLD: next_s.pins.sda_oe_n = 1'b1;
      E_RST, E_STOP: begin
        next_s.pins.sda_oe_n = (s.eng == E_RST);
        if (s.hc == 16'(HALF_CYC - 1)) begin
          next_s.eng = (s.eng == E_RST) ? E_RST2 : E_STOP2;
          next_s.hc = 16'h0;
        end
      end
      E_RST2, E_STOP2: begin
        if (!f_scl) begin
          next_s.hc = 16'h0;
        end else if (s.hc == 16'(HALF_CYC - 1)) begin
          next_s.hc = 16'h0;
          next_s.pins.sda_oe_n = 1'b1;
          next_s.eng = (s.eng == E_RST2) ? E_START : E_IDLE;
          next_s.bs = (s.eng == E_RST2) ? BS_OWNER : BS_IDLE;
        end
      end
      default: next_s.eng = E_IDLE;
    endcase

    // Bus monitor
    if ((start_ev || stop_ev) && (s.eng == E_LOW || s.eng == E_HIGH ||
        s.eng == E_HOLD))
      set_err = 1'b1;
    if (start_ev) begin
      next_s.fresh = 1'b1;
      if (s.eng == E_IDLE || s.eng == E_WAIT)
        next_s.bs = BS_BUSY;
    end
    if (stop_ev) begin
      if (s.fresh)
        set_err = 1'b1;
      if (s.eng == E_IDLE || s.eng == E_WAIT)
        next_s.bs = BS_IDLE;
    end
    if (!s.scl && f_scl)
      next_s.fresh = 1'b0;
    // Our own stretch is not a bus fault
    if (f_scl || (s.eng == E_HOLD && s.hold) || s.bs == BS_IDLE)
      next_s.tc = 20'h0;
    else if (s.tc != 20'(TOUT_CYC))
      next_s.tc = s.tc + 20'h1;
    if (s.tc == 20'(TOUT_CYC - 1)) begin
      set_tout = 1'b1;
      if (s.bs == BS_OWNER || s.bs == BS_BUSY)
        set_err = 1'b1;
    end
    if (set_err && s.bs == BS_OWNER)
      lost = 1'b1;
    if (lost) begin
      set_arb = 1'b1;
      set_mb = 1'b1;
      next_s.hold = 1'b0;
      next_s.pins.sda_oe_n = 1'b1;
      next_s.eng = E_IDLE;
      next_s.bs = stop_ev ? BS_IDLE : BS_BUSY;
    end

    // Register bus
    if (req.awvalid && s.rsp.awready) begin
      next_s.aw_ok = 1'b1;
      next_s.aw = req.awaddr;
    end
    if (req.wvalid && s.rsp.wready) begin
      next_s.w_ok = 1'b1;
      next_s.wd = req.wdata;
      next_s.ws = req.wstrb;
    end
    if (s.rsp.bvalid && req.bready)
      next_s.rsp.bvalid = 1'b0;
    if (wr_fire) begin
      next_s.aw_ok = 1'b0;
      next_s.w_ok = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = mapped(widx) ? RESP_OKAY : RESP_SLVERR;
      case (widx)
        IDX_FLAGS: begin
          if (wm[F_MB]) next_s.mb = 1'b0;
          if (wm[F_SB]) next_s.sb = 1'b0;
        end
        IDX_STATUS: begin
          if (wm[S_ERR]) next_s.illegal_condition_flag = 1'b0;
          if (wm[S_ARB]) next_s.arb = 1'b0;
          if (wm[S_TOUT]) next_s.tout = 1'b0;
          if (wm[S_HOLD]) next_s.hold = 1'b0;
          if (s.ws[0] && s.wd[S_BS +: 2] == 2'h1 &&
              s.bs == BS_UNKNOWN) begin
            next_s.bs = BS_IDLE;
            next_s.system_op_pending = 1'b1;
            sync_go = 1'b1;
          end
        end
        IDX_ADDR: if (s.ws[0]) begin
          next_s.addr = s.wd[7:0];
          next_s.rd = s.wd[0];
          next_s.addrph = 1'b1;
          {next_s.illegal_condition_flag, next_s.arb, next_s.tout} = 3'h0;
          {next_s.mb, next_s.sb} = 2'h0;
          sync_go = 1'b1;
          case (s.bs)
            BS_UNKNOWN: {set_mb, set_err} = 2'h3;
            BS_IDLE: if (s.eng == E_IDLE) begin
              next_s.eng = E_START;
              next_s.hc = 16'h0;
              next_s.bs = BS_OWNER;
            end
            BS_BUSY: if (s.eng == E_IDLE) next_s.eng = E_WAIT;
            default: if (s.eng == E_HOLD) begin
              rel = 1'b1;
              ack_first = s.rxh;
              op = CMD_RSTART;
              dst = E_RST;
            end
          endcase
        end
        IDX_DATA: if (s.ws[0]) begin
          next_s.dat = s.wd[7:0];
          if (s.eng == E_HOLD) begin
            rel = 1'b1;
            ack_first = s.rxh;
            dst = E_LOW;
            next_s.bitn = s.rxh ? s.bitn : 4'h0;
            next_s.sh = s.rxh ? s.sh : s.wd[7:0];
          end
        end
        IDX_CTRL: begin
          if (s.ws[1]) next_s.autoack = s.wd[C_AUTO];
          if (s.ws[2]) begin
            next_s.ack_response_select = s.wd[C_ACK];
            cmd = s.wd[C_CMD +: 2];
          end
          if (cmd != 2'h0 && s.eng == E_HOLD &&
              (cmd != CMD_READ || s.rxh)) begin
            rel = 1'b1;
            sync_go = 1'b1;
            next_s.system_op_pending = 1'b1;
            ack_first = s.rxh;
            op = cmd;
            dst = (cmd == CMD_RSTART) ? E_RST : E_STOP;
          end
        end
        default: ;
      endcase
    end
    if (s.rsp.rvalid && req.rready)
      next_s.rsp.rvalid = 1'b0;
    if (req.arvalid && s.rsp.arready) begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rresp = mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
      case (ridx)
        IDX_FLAGS: {rdv[F_SB], rdv[F_MB]} = {s.sb, s.mb};
        IDX_STATUS: begin
          {rdv[S_SYNC], rdv[S_HOLD], rdv[S_TOUT]} = {s.sync, s.hold, s.tout};
          rdv[S_BS +: 2] = s.bs;
          {rdv[S_NACK], rdv[S_ARB], rdv[S_ERR]} = {s.last_byte_refused, s.arb, s.illegal_condition_flag};
        end
        IDX_ADDR: rdv[7:0] = s.addr;
        IDX_DATA: begin
          rdv[7:0] = s.dat;
          if (s.autoack && s.rxh && s.eng == E_HOLD) begin
            rel = 1'b1;
            ack_first = 1'b1;
            sync_go = 1'b1;
          end
        end
        IDX_CTRL: begin
          {rdv[C_ACK], rdv[C_AUTO]} = {s.ack_response_select, s.autoack};
          rdv[C_SYSTEM_OP_PENDING] = s.system_op_pending;
        end
        default: ;
      endcase
      next_s.rsp.rdata = rdv;
    end

    // Release only a still-held transfer; an abort takes precedence
    if (rel && next_s.eng == E_HOLD) begin
      {next_s.mb, next_s.sb, next_s.hold} = 3'h0;
      next_s.hc = 16'h0;
      next_s.eng = ack_first ? E_LOW : dst;
      if (ack_first) begin
        next_s.nxt = op;
        next_s.bitn = 4'h8;
      end
    end
    if (sync_go) begin
      next_s.sync = 1'b1;
      next_s.sc = 2'(SYNC_CYC);
    end else if (s.sc != 2'h0) begin
      next_s.sc = s.sc - 2'h1;
      if (s.sc == 2'h1)
        {next_s.sync, next_s.system_op_pending} = 2'h0;
    end
    // Hardware sets win over same-cycle clears
    next_s.mb = next_s.mb | set_mb;
    next_s.sb = next_s.sb | set_sb;
    next_s.arb = next_s.arb | set_arb;
    next_s.illegal_condition_flag = next_s.illegal_condition_flag | set_err;
    next_s.tout = next_s.tout | set_tout;
    next_s.rsp.awready = !next_s.aw_ok;
    next_s.rsp.wready = !next_s.w_ok;
    next_s.rsp.arready = !next_s.rsp.rvalid;
    next_s.pins.scl_oe_n = !(next_s.eng == E_LOW || next_s.eng == E_RST ||
      next_s.eng == E_STOP || (next_s.eng == E_HOLD && next_s.hold));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.pins.scl_oe_n <= 1'b1;
      s.pins.sda_oe_n <= 1'b1;
      {s.scl, s.sda, s.scl_s, s.sda_s} <= 8'hff;
    end else begin
      s <= next_s;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence rx_byte_end;
    s.eng == E_HIGH && f_scl && s.hc == 16'(HALF_CYC - 1) &&
    s.bitn == 4'h7 && !tx;
  endsequence
  sequence tx_ack_end;
    s.eng == E_HIGH && f_scl && s.hc == 16'(HALF_CYC - 1) &&
    s.bitn == 4'h8 && tx;
  endsequence
  sequence addr_write;
    wr_fire && widx == IDX_ADDR && s.ws[0];
  endsequence

  a_rx_sets_sb: assert property (rx_byte_end ##0 !lost |=>
    s.sb && s.hold && !s.pins.scl_oe_n) else $error("no client flag");
  a_tx_sets_mb: assert property (tx_ack_end ##0 !(s.addrph && s.rd &&
    !s.sda) |=> s.mb) else $error("no host flag after byte");
  a_hold_stretch: assert property (s.eng == E_HOLD && s.hold
    |-> !s.pins.scl_oe_n) else $error("held clock not low");
  a_lost_released: assert property (lost |=> s.arb && s.mb &&
    s.pins.scl_oe_n [*2]) else $error("lost without release");
  a_sync_span: assert property (addr_write |=> s.sync [*2])
    else $error("sync busy not shown");
  a_unknown_addr: assert property (addr_write ##0 s.bs == BS_UNKNOWN
    |=> s.mb && s.illegal_condition_flag && s.eng != E_START) else $error("unknown start");
  a_addr_clears: assert property (addr_write ##0 !set_arb ##0 !set_tout
    ##0 s.bs != BS_UNKNOWN |=> !s.arb && !s.tout) else $error("no clear");
  a_force_idle: assert property (wr_fire && widx == IDX_STATUS &&
    s.ws[0] && s.wd[5:4] == 2'h1 && s.bs == BS_UNKNOWN && !start_ev
    |=> s.bs == BS_IDLE && s.system_op_pending) else $error("force idle failed");
  a_nack_ro: assert property (wr_fire && widx == IDX_STATUS &&
    s.eng == E_HOLD |=> $stable(s.last_byte_refused)) else $error("nack written");
  a_tout_flag: assert property (set_tout |=> s.tout)
    else $error("time-out not flagged");
endmodule

// ---- testbench/i2c_client_model.sv ----
// Purpose: Behavioural client device on the two-wire bus
// Assumes: Lines pulled high; drives data low only after a clock fall
// Notes: Refuses data bytes while refuse is high
`timescale 1ns/100ps
module i2c_client_model #(
  parameter logic [6:0] DEV = 7'h3a
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] tx,
  input wire logic refuse,
  output logic sda_low,
  output logic [7:0] rx,
  output logic mack
);
  logic rs = 1'b0;
  logic [7:0] sh;
  task automatic drive(input logic val);
    @(negedge scl);
    sda_low = val;
  endtask
  task automatic take;
    repeat (8) begin
      @(posedge scl);
      sh = {sh[6:0], sda};
    end
  endtask
  initial sda_low = 1'b0;
  // Start restarts the frame even mid-byte
  always @(negedge sda) if (scl === 1'b1) begin
    rs = 1'b1;
    sda_low = 1'b0;
    disable frame;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    sda_low = 1'b0;
    disable frame;
  end
  always begin : frame
    wait (rs);
    rs = 1'b0;
    take;
    drive(sh[7:1] == DEV);
    if (sh[7:1] == DEV && sh[0]) begin
      do begin
        for (int i = 7; i >= 0; i--) drive(~tx[i]);
        drive(1'b0);
        @(posedge scl);
        mack = sda;
      end while (!mack);
    end else if (sh[7:1] == DEV) begin
      forever begin
        drive(1'b0);
        take;
        rx = sh;
        drive(~refuse);
      end
    end
    drive(1'b0);
  end
endmodule

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench of the two-wire host flag block
// Assumes: One client model, pull-ups on both lines
// Notes: Short half bit keeps each byte under a hundred cycles
`timescale 1ns/100ps
module tb;
  import i2c_host_pkg::*;
  localparam logic [6:0] DEV = 7'h3a;
  localparam logic [9:0] A_CT = {IDX_CTRL, 2'b00};
  localparam logic [9:0] A_FL = {IDX_FLAGS, 2'b00};
  localparam logic [9:0] A_ST = {IDX_STATUS, 2'b00};
  localparam logic [9:0] A_AD = {IDX_ADDR, 2'b00};
  localparam logic [9:0] A_DA = {IDX_DATA, 2'b00};
  localparam logic [31:0] M = 32'h00b7;
  logic aclk, aresetn, x_sda, refuse, sda_low, mack;
  logic [7:0] tx, rx, b;
  logic [31:0] v;
  logic [1:0] resp;
  logic [9:0] rg [4];
  axi_req_type req;
  axi_rsp_type rsp;
  pins_type pins;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  wire scl_line = pins.scl_oe_n;
  wire sda_line = pins.sda_oe_n & ~sda_low & ~x_sda;
  i2c_host_flags #(.HALF_CYC(4), .TOUT_CYC(200)) uut (.aclk(aclk),
    .aresetn(aresetn), .req(req), .rsp(rsp), .scl_in(scl_line),
    .sda_in(sda_line), .pins(pins));
  i2c_client_model #(.DEV(DEV)) client (.scl(scl_line), .sda(sda_line),
    .tx(tx), .refuse(refuse), .sda_low(sda_low), .rx(rx), .mack(mack));
  always #25 aclk = ~aclk;
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] st(input logic [1:0] bs,
    input logic h, input logic n, input logic a, input logic e);
    st = '0;
    st[S_HOLD] = h;
    st[S_BS +: 2] = bs;
    st[S_NACK] = n;
    st[S_ARB] = a;
    st[S_ERR] = e;
  endfunction
  // Readiness sampled half a cycle before the taking edge
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic ka, kw, kb;
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(negedge aclk);
      ka = rsp.awready === 1'b1;
      kw = rsp.wready === 1'b1;
      kb = rsp.bvalid === 1'b1;
      resp = rsp.bresp;
      @(posedge aclk);
      if (ka) req.awvalid <= 1'b0;
      if (kw) req.wvalid <= 1'b0;
    end while (!kb);
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    logic ka, kr;
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(negedge aclk);
      ka = rsp.arready === 1'b1;
      kr = rsp.rvalid === 1'b1;
      d = rsp.rdata;
      resp = rsp.rresp;
      @(posedge aclk);
      if (ka) req.arvalid <= 1'b0;
    end while (!kr);
    req.rready <= 1'b0;
  endtask
  task automatic wait_for(input logic [9:0] a, input logic [31:0] m,
    input logic [31:0] e);
    int n;
    n = 0;
    do begin
      rd(a, v);
      n++;
    end while ((v & m) !== e && n < 400);
    // A poll that never settles ends the run as a failure
    if (n >= 400) begin
      err_total++;
      tally_and_finish;
    end
  endtask
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    req = '0;
    x_sda = 1'b0;
    refuse = 1'b0;
    tx = 8'h00;
    rg = '{A_FL, A_ST, A_AD, A_DA};
    void'($urandom(32'h1b9e34a3));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(rg[i], v);
      chk(v, 32'h0);
    end
    rd(10'h3fc, v);
    chk(resp, RESP_SLVERR);
    // Address write before the bus state is known
    wr(A_AD, 32'h74);
    rd(A_FL, v);
    chk(v, 32'h1);
    rd(A_ST, v);
    chk(v & M, st(BS_UNKNOWN, 0, 0, 0, 1));
    wr(A_ST, 32'h0);
    rd(A_ST, v);
    chk(v[S_ERR], 1'b1);
    wr(A_ST, 32'h1);
    wr(A_FL, 32'h1);
    wr(A_ST, 32'h20);
    rd(A_ST, v);
    chk(v & M, st(BS_UNKNOWN, 0, 0, 0, 0));
    wr(A_ST, 32'h10);
    wr(A_ST, 32'h30);
    rd(A_ST, v);
    chk(v & M, st(BS_IDLE, 0, 0, 0, 0));
    // Write transfer, last byte refused
    wr(A_AD, {24'h0, DEV, 1'b0});
    wait_for(A_FL, 32'h3, 32'h1);
    chk(v, 32'h1);
    rd(A_ST, v);
    chk(v & M, st(BS_OWNER, 1, 0, 0, 0));
    rd(A_AD, v);
    chk(v, {24'h0, DEV, 1'b0});
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      refuse <= (i == 2);
      wr(A_DA, {24'h0, b});
      rd(A_FL, v);
      chk(v, 32'h0);
      wait_for(A_FL, 32'h3, 32'h1);
      chk(v, 32'h1);
      chk(rx, b);
      rd(A_ST, v);
      chk(v & M, st(BS_OWNER, 1, i == 2, 0, 0));
    end
    wr(A_ST, 32'h4);
    wr(A_FL, 32'h0);
    rd(A_FL, v);
    chk(v, 32'h1);
    wr(A_FL, 32'h1);
    rd(A_FL, v);
    chk(v, 32'h0);
    rd(A_ST, v);
    chk(v & M, st(BS_OWNER, 1, 1, 0, 0));
    wr(A_CT, {14'h0, CMD_STOP, 16'h0});
    wait_for(A_ST, 32'h30, 32'h10);
    chk(v & 32'hb0, st(BS_IDLE, 0, 0, 0, 0));
    // Read transfer with auto acknowledge
    refuse <= 1'b0;
    tx <= 8'($urandom);
    wr(A_CT, 32'h1 << C_AUTO);
    wr(A_AD, {24'h0, DEV, 1'b1});
    for (int i = 0; i < 3; i++) begin
      wait_for(A_FL, 32'h3, 32'h2);
      chk(v, 32'h2);
      b = tx;
      if (i > 0) chk(mack, 1'b0);
      if (i == 0) begin
        wr(A_FL, 32'h2);
        rd(A_FL, v);
        chk(v, 32'h0);
        repeat (100) @(posedge aclk);
        rd(A_ST, v);
        chk(v & M, st(BS_OWNER, 1, 0, 0, 0));
      end
      tx <= 8'($urandom);
      if (i < 2) rd(A_DA, v);
      if (i < 2) chk(v, {24'h0, b});
    end
    wr(A_CT, {13'h0, 1'b1, CMD_STOP, 16'h0100});
    wait_for(A_ST, 32'h30, 32'h10);
    chk(mack, 1'b1);
    rd(A_DA, v);
    chk(v, {24'h0, b});
    // Another host wins during the first address bit
    wr(A_CT, 32'h0);
    wr(A_AD, {24'h0, 7'h7f, 1'b0});
    @(negedge scl_line);
    @(posedge aclk);
    x_sda <= 1'b1;
    wait_for(A_FL, 32'h1, 32'h1);
    rd(A_ST, v);
    chk(v[S_ARB], 1'b1);
    @(posedge aclk);
    x_sda <= 1'b0;
    wait_for(A_ST, 32'h30, 32'h10);
    chk(v[S_BS +: 2], BS_IDLE);
    wr(A_ST, 32'h0);
    rd(A_ST, v);
    chk(v[S_ARB], 1'b1);
    wr(A_ST, 32'h2);
    rd(A_ST, v);
    chk(v[S_ARB], 1'b0);
    tally_and_finish;
  end
endmodule
